// >>> dv/fdcr_dma_model.sv
/*
  dma controller model standing on the host side of the floppy reset block.
  assumes the bench clock and reset; answers a held request on its resp_cyc_i + 1th cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module fdcr_dma_model
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] resp_cyc_i,
  input wire logic drq_i,
  output logic dack_n_o
);
  logic [3:0] wait_r;

  // --------------------------------------------------------------------
  // acknowledge, chip select never used by this model
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !drq_i)
    begin
      wait_r <= 4'h0;
      dack_n_o <= 1'b1;
    end
    else if (wait_r == resp_cyc_i)
    begin
      dack_n_o <= 1'b0;
    end
    else
    begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

`default_nettype wire

// >>> dv/fdcr_reset_and_input_status_tb.sv
/*
  self-checking bench of the floppy reset and input status block.
  assumes fdcr_map.svh offsets and a dma model beside the design.
*/
`include "fdcr_map.svh"
`timescale 1ns/100ps
`default_nettype none

module fdc_reset_and_input_status_tb;
  import fdcr_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, chg_n, auto_pd, xreq, dack_n;
  logic rd_d, win, core_rst, fifo_rst, pd, poll, drq, facc, ds0, ds1, osc, lock, bval;
  fdcr_addr_t paddr;
  fdcr_word_t pwdata, prdata, rd_q;
  logic [7:0] oe, oe_q, cbyte, dbyte;
  logic [1:0] dens, rate;
  logic [2:0] shift;
  logic [3:0] thr;
  logic err_q;
  logic ce;
  int err_count = 0;
  int cmp_count = 0;

  fdcr_reset_status uut (.core_clk_i(clk), .srst_i(srst), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .disk_in_oe_o(oe),
    .disk_changed_n_i(chg_n), .auto_pd_i(auto_pd), .xfer_req_i(xreq), .dack_n_i(dack_n),
    .density_i(dens), .rd_data_i(rd_d), .data_window_i(win), .core_reset_o(core_rst),
    .fifo_reset_o(fifo_rst), .powerdown_o(pd), .poll_start_o(poll), .drq_o(drq),
    .fifo_access_o(facc), .density_select_0_o(ds0), .density_select_1_o(ds1),
    .rate_field_o(rate), .write_shift_field_o(shift), .osc_powerdown_o(osc),
    .fifo_lock_o(lock), .fifo_thr_o(thr), .clk_byte_o(cbyte), .data_byte_o(dbyte),
    .byte_valid_o(bval));

  fdcr_dma_model dma (.clk_i(clk), .srst_i(srst), .resp_cyc_i(4'h3), .drq_i(drq),
    .dack_n_o(dack_n));

  // --------------------------------------------------------------------
  // common tasks
  // --------------------------------------------------------------------
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input fdcr_addr_t a, input fdcr_word_t d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd_q = prdata;
    err_q = pslverr;
    oe_q = oe;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // waits for drq (sel 0), fifo access (1), poll pulse (2) or byte valid (3)
  task automatic wait_sig(input int sel, input int lim, output logic seen);
    seen = 1'b0;
    repeat (lim)
    begin
      @(posedge clk);
      if ((sel == 0 && drq === 1'b1) || (sel == 1 && facc === 1'b1 && psel === 1'b0) ||
          (sel == 2 && poll === 1'b1) || (sel == 3 && bval === 1'b1))
        seen = 1'b1;
    end
  endtask

  task automatic leave_reset();
    logic s;
    cyc(30);
    apb(1'b1, `FDCR_OFS_DRIVE_CTRL, 32'h0);
    wait_sig(2, 10, s);
    chk(s, 1'b1, "poll start");
    chk(core_rst, 1'b0, "core out of reset");
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_pin_reset();
    srst <= 1'b1;
    cyc(4);
    srst <= 1'b0;
    cyc(2);
    chk(core_rst, 1'b1, "pin reset sets ctrl bit");
    chk(rate, `FDCR_RATE_DEFAULT, "rate default");
    chk(osc, 1'b0, "osc pd cleared");
    chk(fifo_rst, 1'b1, "fifo reset");
    leave_reset();
  endtask

  task automatic disk_case(input logic c, input logic a, input logic e);
    chg_n <= c;
    auto_pd <= a;
    cyc(8);
    apb(1'b0, `FDCR_OFS_DISK_IN, 32'h0);
    chk(rd_q[7], e, "disk changed bit");
    chk(oe_q, 8'h80, "only bit 7 driven");
  endtask

  task automatic t_powerdown();
    apb(1'b1, `FDCR_OFS_RATE_SEL, 32'h42);
    cyc(2);
    chk(pd, 1'b1, "powerdown set");
    apb(1'b1, `FDCR_OFS_DRIVE_CTRL, 32'h4);
    cyc(2);
    chk(pd, 1'b0, "reset ends powerdown");
    chk(core_rst, 1'b1, "ctrl reset source");
    leave_reset();
  endtask

  task automatic t_soft();
    apb(1'b1, `FDCR_OFS_OPTIONS, 32'ha1);
    apb(1'b1, `FDCR_OFS_RATE_SEL, 32'h35);
    apb(1'b1, `FDCR_OFS_RATE_SEL, 32'hb5);
    cyc(2);
    chk(core_rst, 1'b1, "rate soft reset");
    chk(fifo_rst, 1'b0, "locked fifo kept");
    cyc(40);
    apb(1'b0, `FDCR_OFS_RATE_SEL, 32'h0);
    chk(rd_q[7:0], 8'h35, "self clear, rate kept");
    chk(thr, 4'ha, "threshold kept");
    chk(lock, 1'b1, "lock kept");
    chk(shift, 3'h5, "shift kept");
    chk(core_rst, 1'b0, "soft reset over");
    apb(1'b1, `FDCR_OFS_OPTIONS, 32'ha0);
    apb(1'b1, `FDCR_OFS_RATE_SEL, 32'hb5);
    cyc(2);
    chk(fifo_rst, 1'b1, "unlocked fifo reset");
    cyc(40);
    chk(thr, 4'h0, "threshold cleared");
    chk(osc, 1'b1, "osc pd kept");
  endtask

  task automatic t_prec();
    apb(1'b1, `FDCR_OFS_DRIVE_CTRL, 32'h4);
    apb(1'b1, `FDCR_OFS_RATE_SEL, 32'hb5);
    cyc(40);
    chk(core_rst, 1'b1, "ctrl reset holds");
    apb(1'b0, `FDCR_OFS_CORE_STAT, 32'h0);
    chk(rd_q[4:3], 2'h2, "ctrl source wins");
    leave_reset();
  endtask

  task automatic t_dma();
    logic s;
    apb(1'b1, `FDCR_OFS_TIMING, 32'h1);
    xreq <= 1'b1;
    wait_sig(0, 10, s);
    chk(s, 1'b1, "drq raised");
    wait_sig(1, 20, s);
    chk(s, 1'b1, "dack opens fifo");
    xreq <= 1'b0;
    t_pin_reset();
    xreq <= 1'b1;
    wait_sig(0, 10, s);
    chk(s, 1'b1, "dma mode survives pin reset");
    xreq <= 1'b0;
  endtask

  task automatic t_density();
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, `FDCR_OFS_DRIVE_SPEC, fdcr_word_t'(p));
      dens <= 2'b01;
      cyc(3);
      chk({ds1, ds0}, 2'b01 ^ p[1:0], "density polarity");
    end
  endtask

  // a control reset written while the clock enable is low must not take
  task automatic t_freeze();
    ce <= 1'b0;
    apb(1'b1, `FDCR_OFS_DRIVE_CTRL, 32'h4);
    cyc(3);
    ce <= 1'b1;
    cyc(2);
    chk(core_rst, 1'b0, "write ignored while frozen");
  endtask

  task automatic t_deser();
    logic [7:0] cp, dp;
    logic s;
    cp = 8'h2c;
    dp = 8'hb1;
    for (int i = 7; i >= 0; i--)
    begin
      win <= 1'b0;
      cyc(3);
      rd_d <= cp[i];
      cyc(2);
      rd_d <= 1'b0;
      cyc(3);
      win <= 1'b1;
      cyc(3);
      rd_d <= dp[i];
      cyc(2);
      rd_d <= 1'b0;
      cyc(3);
    end
    win <= 1'b0;
    wait_sig(3, 10, s);
    chk(s, 1'b1, "byte valid");
    chk(dbyte, dp, "data byte");
    chk(cbyte, cp, "clock byte");
  endtask

  // --------------------------------------------------------------------
  // clock, watchdog and main sequence
  // --------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #1000000;
    err_count++;
    results();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    {chg_n, auto_pd, xreq, dens, rd_d, win} = 7'b1000000;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    cyc(2);
    chk(core_rst, 1'b1, "reset value ctrl");
    chk(rate, `FDCR_RATE_DEFAULT, "reset value rate");
    leave_reset();
    disk_case(1'b0, 1'b0, 1'b1);
    disk_case(1'b1, 1'b0, 1'b0);
    disk_case(1'b0, 1'b1, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk(err_q, 1'b1, "unmapped error");
    t_powerdown();
    t_soft();
    t_prec();
    t_dma();
    t_density();
    t_freeze();
    t_deser();
    results();
  end
endmodule

`default_nettype wire

// >>> hw/fdcr_map.svh
/*
  register offsets, field positions, reset values and timing counts of the
  floppy reset and input status block.
  assumes a 32-bit apb bus with byte addresses on the low 8 bits.
*/
`ifndef FDCR_MAP_SVH
`define FDCR_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FDCR_OFS_DRIVE_CTRL 8'h00
`define FDCR_OFS_RATE_SEL 8'h04
`define FDCR_OFS_DISK_IN 8'h08
`define FDCR_OFS_TIMING 8'h0c
`define FDCR_OFS_OPTIONS 8'h10
`define FDCR_OFS_DRIVE_SPEC 8'h14
`define FDCR_OFS_CORE_STAT 8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FDCR_CTRL_RESET_BIT 2
`define FDCR_RATE_LO 0
`define FDCR_SHIFT_LO 2
`define FDCR_OSC_PD_BIT 5
`define FDCR_PD_BIT 6
`define FDCR_RATE_RESET_BIT 7
`define FDCR_DISK_CHG_BIT 7
`define FDCR_TIM_DMA_BIT 0
`define FDCR_OPT_LOCK_BIT 0
`define FDCR_OPT_NOPOLL_BIT 1
`define FDCR_OPT_THR_LO 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FDCR_RATE_DEFAULT 2'b10
`define FDCR_SHIFT_DEFAULT 3'h0
`define FDCR_THR_DEFAULT 4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FDCR_CLK_NS 20
`define FDCR_RST_HOLD_NS 500
`define FDCR_RST_HOLD_CYC ((`FDCR_RST_HOLD_NS + `FDCR_CLK_NS - 1) / `FDCR_CLK_NS)

`endif

// >>> hw/fdcr_pkg.sv
/*
  types of the floppy reset and input status block.
  assumes fdcr_map.svh for all numeric constants.
*/
package fdcr_pkg;
  typedef logic [7:0] fdcr_addr_t;
  typedef logic [31:0] fdcr_word_t;
  typedef logic [4:0] fdcr_cnt_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_PIN, SRC_CTRL, SRC_RATE} fdcr_src_e;
  typedef enum logic {PH_RUN, PH_RESET} fdcr_phase_e;
endpackage

// >>> hw/fdcr_reset_status.sv
/*
  reset control, disk input status, dma gating, density polarity and
  read-data deserialiser of a floppy disk controller, with an apb slave.
  assumes srst_i is the reset pin, already on core_clk_i; drive cable
  inputs are asynchronous and are synchronised here.
*/
// The register offsets and register access over APB were decided locally.
`include "fdcr_map.svh"
`timescale 1ns/100ps
`default_nettype none

module fdcr_reset_status
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire fdcr_pkg::fdcr_addr_t paddr_i,
  input wire fdcr_pkg::fdcr_word_t pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output fdcr_pkg::fdcr_word_t prdata_o,
  output logic [7:0] disk_in_oe_o,
  input wire logic disk_changed_n_i,
  input wire logic auto_pd_i,
  input wire logic xfer_req_i,
  input wire logic dack_n_i,
  input wire logic [1:0] density_i,
  input wire logic rd_data_i,
  input wire logic data_window_i,
  output logic core_reset_o,
  output logic fifo_reset_o,
  output logic powerdown_o,
  output logic poll_start_o,
  output logic drq_o,
  output logic fifo_access_o,
  output logic density_select_0_o,
  output logic density_select_1_o,
  output logic [1:0] rate_field_o,
  output logic [2:0] write_shift_field_o,
  output logic osc_powerdown_o,
  output logic fifo_lock_o,
  output logic [3:0] fifo_thr_o,
  output logic [7:0] clk_byte_o,
  output logic [7:0] data_byte_o,
  output logic byte_valid_o
);
  import fdcr_pkg::*;

  localparam fdcr_cnt_t HOLD_CYC = fdcr_cnt_t'(`FDCR_RST_HOLD_CYC);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] chg_s_r;
  logic [2:0] dack_s_r;
  logic [2:0] rd_s_r;
  logic [2:0] win_s_r;
  logic chg_n_r;
  logic dack_n_r;
  logic rd_r;
  logic win_r;

  function automatic logic agree(input logic [2:0] s, input logic old);
    agree = (s[1] == s[2]) ? s[2] : old;
  endfunction

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      chg_s_r <= 3'h7;
      dack_s_r <= 3'h7;
      rd_s_r <= 3'h0;
      win_s_r <= 3'h0;
      chg_n_r <= 1'b1;
      dack_n_r <= 1'b1;
      rd_r <= 1'b0;
      win_r <= 1'b0;
    end
    else if (ce_i)
    begin
      chg_s_r <= {chg_s_r[1:0], disk_changed_n_i};
      dack_s_r <= {dack_s_r[1:0], dack_n_i};
      rd_s_r <= {rd_s_r[1:0], rd_data_i};
      win_s_r <= {win_s_r[1:0], data_window_i};
      chg_n_r <= agree(chg_s_r, chg_n_r);
      dack_n_r <= agree(dack_s_r, dack_n_r);
      rd_r <= agree(rd_s_r, rd_r);
      win_r <= agree(win_s_r, win_r);
    end
  end

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic wr_en;
  logic rd_setup;
  logic mapped;

  always_comb
  begin
    unique case (paddr_i)
      `FDCR_OFS_DRIVE_CTRL, `FDCR_OFS_RATE_SEL, `FDCR_OFS_DISK_IN,
      `FDCR_OFS_TIMING, `FDCR_OFS_OPTIONS, `FDCR_OFS_DRIVE_SPEC,
      `FDCR_OFS_CORE_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign wr_en = ce_i & psel_i & penable_i & pwrite_i;
  assign rd_setup = ce_i & psel_i & ~penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  function automatic logic hit(input fdcr_addr_t a, input fdcr_addr_t ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------------
  logic ctrl_reset_r;
  logic rate_reset_r;
  fdcr_cnt_t hold_cnt_r;
  fdcr_src_e src_r;
  fdcr_phase_e phase_r;
  logic soft_any;
  logic hold_done;

  assign soft_any = ctrl_reset_r | rate_reset_r;
  assign hold_done = (hold_cnt_r == HOLD_CYC);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      ctrl_reset_r <= 1'b1;
    else if (wr_en && hit(paddr_i, `FDCR_OFS_DRIVE_CTRL))
      ctrl_reset_r <= pwdata_i[`FDCR_CTRL_RESET_BIT];
  end

  // a fresh write wins over the self-clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      rate_reset_r <= 1'b0;
    else if (wr_en && hit(paddr_i, `FDCR_OFS_RATE_SEL) && pwdata_i[`FDCR_RATE_RESET_BIT])
      rate_reset_r <= 1'b1;
    else if (ce_i && hold_done && !ctrl_reset_r)
      rate_reset_r <= 1'b0;
  end

  // minimum hold so a rate soft reset spans a full reset of the core; the control reset clears when written
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      hold_cnt_r <= '0;
    else if (ce_i)
    begin
      if (!soft_any)
        hold_cnt_r <= '0;
      else if (!hold_done)
        hold_cnt_r <= hold_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      src_r <= SRC_PIN;
    else if (ce_i)
    begin
      if (ctrl_reset_r)
        src_r <= SRC_CTRL;
      else if (rate_reset_r)
        src_r <= SRC_RATE;
      else
        src_r <= SRC_NONE;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      phase_r <= PH_RESET;
    else if (ce_i)
    begin
      unique case (phase_r)
        PH_RUN: if (soft_any) phase_r <= PH_RESET;
        PH_RESET: if (!soft_any) phase_r <= PH_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // reset effects
  // ----------------------------------------------------------------------
  logic [1:0] rate_r;
  logic [2:0] shift_r;
  logic osc_pd_r;
  logic pd_r;
  logic lock_r;
  logic nopoll_r;
  logic [3:0] thr_r;
  logic fifo_rst_r;
  logic poll_r;
  logic dma_mode_r = 1'b0;
  logic [1:0] den_pol_r;
  logic in_reset;

  assign in_reset = srst_i | (ce_i & soft_any);
  assign core_reset_o = (phase_r == PH_RESET) | soft_any;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      rate_r <= `FDCR_RATE_DEFAULT;
      shift_r <= `FDCR_SHIFT_DEFAULT;
      osc_pd_r <= 1'b0;
    end
    else if (wr_en && hit(paddr_i, `FDCR_OFS_RATE_SEL))
    begin
      rate_r <= pwdata_i[`FDCR_RATE_LO +: 2];
      shift_r <= pwdata_i[`FDCR_SHIFT_LO +: 3];
      osc_pd_r <= pwdata_i[`FDCR_OSC_PD_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
      pd_r <= 1'b0;
    else if (wr_en && hit(paddr_i, `FDCR_OFS_RATE_SEL))
      pd_r <= pwdata_i[`FDCR_PD_BIT];
  end

  // fifo setup survives a soft reset only while locked
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || (ce_i && soft_any && !lock_r))
    begin
      thr_r <= `FDCR_THR_DEFAULT;
      nopoll_r <= 1'b0;
    end
    else if (wr_en && hit(paddr_i, `FDCR_OFS_OPTIONS))
    begin
      thr_r <= pwdata_i[`FDCR_OPT_THR_LO +: 4];
      nopoll_r <= pwdata_i[`FDCR_OPT_NOPOLL_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      lock_r <= 1'b0;
    else if (wr_en && hit(paddr_i, `FDCR_OFS_OPTIONS))
      lock_r <= pwdata_i[`FDCR_OPT_LOCK_BIT];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      fifo_rst_r <= 1'b1;
    else if (ce_i)
      fifo_rst_r <= soft_any & ~lock_r;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      poll_r <= 1'b0;
    else if (ce_i)
      poll_r <= (phase_r == PH_RESET) & ~soft_any & ~nopoll_r;
  end

  // timing setup survives the reset pin
  always_ff @(posedge core_clk_i)
  begin
    if (wr_en && hit(paddr_i, `FDCR_OFS_TIMING))
      dma_mode_r <= pwdata_i[`FDCR_TIM_DMA_BIT];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      den_pol_r <= 2'b00;
    else if (wr_en && hit(paddr_i, `FDCR_OFS_DRIVE_SPEC))
      den_pol_r <= pwdata_i[1:0];
  end

  assign fifo_reset_o = fifo_rst_r;
  assign poll_start_o = poll_r;
  assign powerdown_o = pd_r;
  assign rate_field_o = rate_r;
  assign write_shift_field_o = shift_r;
  assign osc_powerdown_o = osc_pd_r;
  assign fifo_lock_o = lock_r;
  assign fifo_thr_o = thr_r;

  // ----------------------------------------------------------------------
  // dma and density outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      drq_o <= 1'b0;
      fifo_access_o <= 1'b0;
      density_select_0_o <= 1'b0;
      density_select_1_o <= 1'b0;
    end
    else if (ce_i)
    begin
      drq_o <= dma_mode_r & xfer_req_i & ~core_reset_o;
      fifo_access_o <= ~dack_n_r;
      density_select_0_o <= density_i[0] ^ den_pol_r[0];
      density_select_1_o <= density_i[1] ^ den_pol_r[1];
    end
  end

  // ----------------------------------------------------------------------
  // read data deserialiser
  // ----------------------------------------------------------------------
  logic win_d_r;
  logic pulse_r;
  logic [7:0] clk_sh_r;
  logic [7:0] dat_sh_r;
  logic [2:0] cell_r;

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      win_d_r <= 1'b0;
      pulse_r <= 1'b0;
      clk_sh_r <= 8'h00;
      dat_sh_r <= 8'h00;
      cell_r <= 3'h0;
      clk_byte_o <= 8'h00;
      data_byte_o <= 8'h00;
      byte_valid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      win_d_r <= win_r;
      byte_valid_o <= 1'b0;
      if (win_r != win_d_r)
      begin
        pulse_r <= rd_r;
        if (win_d_r)
          dat_sh_r <= {dat_sh_r[6:0], pulse_r};
        else
          clk_sh_r <= {clk_sh_r[6:0], pulse_r};
        if (win_d_r)
        begin
          cell_r <= cell_r + 3'h1;
          if (cell_r == 3'h7)
          begin
            clk_byte_o <= clk_sh_r;
            data_byte_o <= {dat_sh_r[6:0], pulse_r};
            byte_valid_o <= 1'b1;
          end
        end
      end
      else
        pulse_r <= pulse_r | rd_r;
    end
  end

  // ----------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------
  logic disk_bit;
  logic dir_rd;

  assign disk_bit = auto_pd_i ? 1'b0 : ~chg_n_r;
  assign dir_rd = psel_i & ~pwrite_i & hit(paddr_i, `FDCR_OFS_DISK_IN);
  assign disk_in_oe_o = dir_rd ? 8'h80 : 8'h00;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      prdata_o <= '0;
    else if (rd_setup)
    begin
      prdata_o <= '0;
      unique case (paddr_i)
        `FDCR_OFS_DRIVE_CTRL: prdata_o[`FDCR_CTRL_RESET_BIT] <= ctrl_reset_r;
        `FDCR_OFS_RATE_SEL: prdata_o[7:0] <= {rate_reset_r, pd_r, osc_pd_r, shift_r, rate_r};
        `FDCR_OFS_DISK_IN: prdata_o[`FDCR_DISK_CHG_BIT] <= disk_bit;
        `FDCR_OFS_TIMING: prdata_o[`FDCR_TIM_DMA_BIT] <= dma_mode_r;
        `FDCR_OFS_OPTIONS: prdata_o[7:0] <= {thr_r, 2'b00, nopoll_r, lock_r};
        `FDCR_OFS_DRIVE_SPEC: prdata_o[1:0] <= den_pol_r;
        `FDCR_OFS_CORE_STAT: prdata_o[4:0] <= {src_r, pd_r, core_reset_o, poll_r};
        default: prdata_o <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_rate_rst_wr;
    wr_en && hit(paddr_i, `FDCR_OFS_RATE_SEL) && pwdata_i[`FDCR_RATE_RESET_BIT] && !ctrl_reset_r;
  endsequence
  sequence s_core_held;
    core_reset_o [*8];
  endsequence

  property p_dir_oe;
    dir_rd |-> disk_in_oe_o == 8'h80;
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("dir drives other bits");

  property p_pd_gate;
    auto_pd_i |-> !disk_bit;
  endproperty
  a_pd_gate: assert property (p_pd_gate) else $error("disk bit not gated");

  property p_chg_inv;
    (!auto_pd_i && $stable(chg_n_r)) |-> disk_bit != chg_n_r;
  endproperty
  a_chg_inv: assert property (p_chg_inv) else $error("disk bit not inverted");

  property p_wake;
    soft_any && ce_i |=> !pd_r;
  endproperty
  a_wake: assert property (p_wake) else $error("reset left powerdown");

  // enabled cycles a rate reset has stood with the control reset clear
  logic [5:0] rate_age_r;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !rate_reset_r || ctrl_reset_r)
      rate_age_r <= 6'h00;
    else if (ce_i)
      rate_age_r <= rate_age_r + 6'h01;
  end

  property p_self_clear;
    rate_reset_r |-> rate_age_r <= {1'b0, HOLD_CYC} + 6'h02;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("rate reset stuck");

  property p_hold;
    s_rate_rst_wr ##1 ce_i [*8] |-> s_core_held;
  endproperty
  a_hold: assert property (p_hold) else $error("soft reset too short");

  property p_prec;
    ctrl_reset_r && ce_i |=> src_r == SRC_CTRL;
  endproperty
  a_prec: assert property (p_prec) else $error("control reset lost priority");

  property p_poll;
    $fell(soft_any) && ce_i && !nopoll_r && phase_r == PH_RESET |=> poll_r;
  endproperty
  a_poll: assert property (p_poll) else $error("polling not started");

  property p_lock;
    lock_r && soft_any && ce_i |=> !fifo_rst_r && $stable(thr_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked fifo reset");

  property p_drq;
    ce_i && !dma_mode_r |=> !drq_o;
  endproperty
  a_drq: assert property (p_drq) else $error("drq without dma mode");

  property p_rate_keep;
    soft_any && !wr_en |=> $stable(rate_r) && $stable(osc_pd_r);
  endproperty
  a_rate_keep: assert property (p_rate_keep) else $error("soft reset changed rate");

endmodule

`default_nettype wire
